// >>> rtl/sfo_flash_seq.sv
// Purpose: device-side instruction sequencer of a serial flash
// Assumes: array port answers arr_rdata within one cycle of arr_addr
// Notes: program/erase/status write run self-timed on the core clock
// Functional notes
// (R1) status write (01h) needs latch flag set; one data byte follows the code
// (R2) status write changes only bits 7, 5, 4, 3 and 2
// (R3) status write executes only if select rises right after its eighth data bit
// (R4) status write runs self-timed with busy 1; status stays readable
// (R5) latch flag clears when the status write cycle ends
// (R6) lock bit 1 and guard pin low rejects status writes; lock 0 ignores pin
// (R7) read 03h takes code and 24-bit address msb first on rising edges
// (R8) read data leaves msb first, changing on falling edges
// (R9) read address advances per byte, streaming over the whole memory
// (R10) reads arriving while busy are ignored and leave the cycle alone
// (R11) fast read 0Bh adds eight dummy clocks; input ignored then
// (R12) dual read 3Bh adds dummies then drives both output and bidir line
// (R13) host releases the bidir line before the first data falling edge
// (R14) write enable 06h sets the latch flag needed by writes
// (R15) dual byte takes four clocks: odd bits on output, even on bidir
// (R16) page program 02h needs latch flag, address and one to 256 bytes
// (R17) page load advances only the low 8 address bits, wrapping in page
// (R18) over 256 bytes wrap and overwrite earlier loaded bytes
// (R19) program runs only on byte-aligned select rise; busy, then latch clears
// (R20) program refused when the page lies in the guarded region
// (R21) sector erase 20h needs latch flag; sets its 4K bytes to FFh
// (R22) erase runs only on select rise after address; busy, then latch clears
// (R23) erase refused when the sector lies in the guarded region
// (R24) unknown codes are ignored until select rises
`timescale 1ns/100ps
module sfo_flash_seq (
   input wire logic ref_clk, // core clock, 20 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic cs_n, // chip select pin, active low
   input wire logic sclk, // link clock pin from host
   input wire logic dio_in, // bidir data line, input side
   output logic dio_out, // bidir data line, output side
   output logic dio_oe, // bidir data line drive enable
   output logic do_out, // serial data output pin
   output logic do_oe, // serial data output drive enable
   input wire logic wp_n, // write-guard pin, active low
   output logic [23:0] arr_addr, // array byte or sector address
   input wire logic [7:0] arr_rdata, // array read data
   output logic [7:0] arr_wdata, // array program/erase data
   output logic arr_write, // program one byte, pulse
   output logic arr_erase, // erase sector at arr_addr, pulse
   output logic busy, // self-timed cycle running
   output logic write_latch_flag // write latch flag
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation and edge detection

   logic [3:0] pins_s;
   logic cs_n_s, sclk_s, din_s, wp_n_s;
   logic cs_prev, sclk_prev;
   logic cs_rise, sclk_rise, sclk_fall;

   sfo_sync #(.W(4), .RESET_VAL(sfo_pkg::PIN_RESET)) u_pin_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in({cs_n, sclk, dio_in, wp_n}),
      .sync_out(pins_s)
   );

   assign {cs_n_s, sclk_s, din_s, wp_n_s} = pins_s;
   assign cs_rise = cs_n_s & ~cs_prev;
   assign sclk_rise = sclk_s & ~sclk_prev & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_prev & ~cs_n_s;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cs_prev <= 1'b1;
         sclk_prev <= 1'b0;
      end
      else
      begin
         cs_prev <= cs_n_s;
         sclk_prev <= sclk_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // guarded region decode

   function automatic logic prot_hit(input logic [23:0] a, input logic [7:0] sr);
      logic [2:0] bp;
      logic [23:0] mask;
      logic hit;
      bp = sr[sfo_pkg::SR_BP_HI:sfo_pkg::SR_BP_LO];
      mask = sfo_pkg::ADDR_ONES << (sfo_pkg::PROT_BASE_LOG + 5'(bp));
      if (bp == sfo_pkg::BP_NONE)
         hit = 1'b0;
      else if (bp == sfo_pkg::BP_ALL)
         hit = 1'b1;
      else if (sr[sfo_pkg::SR_TB])
         hit = ((a & mask) == '0);
      else
         hit = ((a & mask) == mask);
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // link side: instruction, address and data shifting

   sfo_pkg::sfo_link_t state, next_state;
   sfo_pkg::sfo_req_t pend, next_pend, req, next_req;
   logic [4:0] cnt, next_cnt;
   logic [7:0] shift, next_shift, sample;
   logic [7:0] op, next_op;
   logic [23:0] addr, next_addr;
   logic [7:0] out_byte, next_out_byte, b;
   logic [7:0] req_data, next_req_data;
   logic next_do, next_do_oe, next_dio, next_dio_oe;
   logic [7:0] page_buf [sfo_pkg::PAGE_BYTES];
   logic [7:0] next_page_buf [sfo_pkg::PAGE_BYTES];
   logic [sfo_pkg::PAGE_BYTES-1:0] loaded, next_loaded;
   logic have_byte, next_have_byte;
   logic [7:0] status;

   always_comb
   begin
      next_state = state;
      next_pend = pend;
      next_req = sfo_pkg::rq_none;
      next_cnt = cnt;
      next_shift = shift;
      next_op = op;
      next_addr = addr;
      next_out_byte = out_byte;
      next_req_data = req_data;
      next_do = do_out;
      next_do_oe = do_oe;
      next_dio = dio_out;
      next_dio_oe = dio_oe;
      next_page_buf = page_buf;
      next_loaded = loaded;
      next_have_byte = have_byte;
      sample = {shift[6:0], din_s};
      b = (cnt == '0) ? ((state == sfo_pkg::lk_read) ? arr_rdata : status) : out_byte;
      if (cs_rise)
      begin
         next_state = sfo_pkg::lk_cmd;
         next_cnt = '0;
         next_do_oe = 1'b0;
         next_dio_oe = 1'b0;
         next_pend = sfo_pkg::rq_none;
         if (state == sfo_pkg::lk_end)
            next_req = pend; // R3 R22
         else if (state == sfo_pkg::lk_ppdata && cnt == '0 && have_byte)
            next_req = sfo_pkg::rq_pp; // R19
      end
      else if (sclk_rise)
      begin
         case (state)
            sfo_pkg::lk_cmd:
            begin
               next_shift = sample; // R7
               next_cnt = cnt + sfo_pkg::STEP_ONE;
               if (cnt == sfo_pkg::BYTE_END)
               begin
                  next_cnt = '0;
                  next_op = sample;
                  next_state = sfo_pkg::lk_ignore; // R24
                  if (sample == sfo_pkg::OP_RDSR)
                     next_state = sfo_pkg::lk_rdsr;
                  else if (busy)
                     next_state = sfo_pkg::lk_ignore; // R10
                  else if (sample == sfo_pkg::OP_WREN)
                  begin
                     next_pend = sfo_pkg::rq_wren; // R14
                     next_state = sfo_pkg::lk_end;
                  end
                  else if (sample == sfo_pkg::OP_WRDI)
                  begin
                     next_pend = sfo_pkg::rq_wrdi;
                     next_state = sfo_pkg::lk_end;
                  end
                  else if (sample == sfo_pkg::OP_WRSR && write_latch_flag)
                     next_state = sfo_pkg::lk_srdata; // R1
                  else if (sample == sfo_pkg::OP_READ || sample == sfo_pkg::OP_FAST
                           || sample == sfo_pkg::OP_DUAL)
                     next_state = sfo_pkg::lk_addr;
                  else if ((sample == sfo_pkg::OP_PP || sample == sfo_pkg::OP_SE)
                           && write_latch_flag)
                     next_state = sfo_pkg::lk_addr; // R16 R21
               end
            end
            sfo_pkg::lk_addr:
            begin
               next_addr = {addr[22:0], din_s}; // R7
               next_cnt = cnt + sfo_pkg::STEP_ONE;
               next_loaded = '0;
               next_have_byte = 1'b0;
               if (cnt == sfo_pkg::ADDR_END)
               begin
                  next_cnt = '0;
                  case (op)
                     sfo_pkg::OP_READ: next_state = sfo_pkg::lk_read;
                     sfo_pkg::OP_PP: next_state = sfo_pkg::lk_ppdata;
                     sfo_pkg::OP_SE:
                     begin
                        next_pend = sfo_pkg::rq_se;
                        next_state = sfo_pkg::lk_end;
                     end
                     default: next_state = sfo_pkg::lk_dummy; // R11 R12
                  endcase
               end
            end
            sfo_pkg::lk_dummy:
            begin
               next_cnt = cnt + sfo_pkg::STEP_ONE; // R11
               if (cnt == sfo_pkg::DUMMY_END)
               begin
                  next_cnt = '0;
                  next_state = sfo_pkg::lk_read;
               end
            end
            sfo_pkg::lk_srdata:
            begin
               next_shift = sample;
               next_cnt = cnt + sfo_pkg::STEP_ONE;
               if (cnt == sfo_pkg::BYTE_END)
               begin
                  next_cnt = '0;
                  next_req_data = sample;
                  next_pend = sfo_pkg::rq_wrsr;
                  next_state = sfo_pkg::lk_end; // R3
               end
            end
            sfo_pkg::lk_ppdata:
            begin
               next_shift = sample;
               next_cnt = cnt + sfo_pkg::STEP_ONE;
               if (cnt == sfo_pkg::BYTE_END)
               begin
                  next_cnt = '0;
                  next_page_buf[addr[7:0]] = sample; // R18
                  next_loaded[addr[7:0]] = 1'b1;
                  next_have_byte = 1'b1;
                  next_addr[7:0] = addr[7:0] + 8'h01; // R17
               end
               else
                  next_have_byte = have_byte;
            end
            sfo_pkg::lk_end: next_state = sfo_pkg::lk_ignore; // R3 R22
            default: next_state = state;
         endcase
      end
      else if (sclk_fall)
      begin
         if (state == sfo_pkg::lk_read && op == sfo_pkg::OP_DUAL)
         begin
            next_do = b[7]; // R15
            next_dio = b[6];
            next_do_oe = 1'b1;
            next_dio_oe = 1'b1; // R12 R13
            next_out_byte = b << 2;
            next_cnt = cnt + sfo_pkg::STEP_TWO;
            if (cnt == sfo_pkg::DUAL_END)
            begin
               next_cnt = '0;
               next_addr = addr + 24'h00_0001; // R9
            end
         end
         else if (state == sfo_pkg::lk_read || state == sfo_pkg::lk_rdsr)
         begin
            next_do = b[7]; // R8
            next_do_oe = 1'b1;
            next_out_byte = b << 1;
            next_cnt = cnt + sfo_pkg::STEP_ONE;
            if (cnt == sfo_pkg::BYTE_END)
            begin
               next_cnt = '0;
               if (state == sfo_pkg::lk_read)
                  next_addr = addr + 24'h00_0001; // R9
            end
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state <= sfo_pkg::lk_cmd;
         pend <= sfo_pkg::rq_none;
         req <= sfo_pkg::rq_none;
         cnt <= '0;
         shift <= '0;
         op <= '0;
         addr <= '0;
         out_byte <= '0;
         req_data <= '0;
         do_out <= 1'b0;
         do_oe <= 1'b0;
         dio_out <= 1'b0;
         dio_oe <= 1'b0;
         loaded <= '0;
         have_byte <= 1'b0;
      end
      else
      begin
         state <= next_state;
         pend <= next_pend;
         req <= next_req;
         cnt <= next_cnt;
         shift <= next_shift;
         op <= next_op;
         addr <= next_addr;
         out_byte <= next_out_byte;
         req_data <= next_req_data;
         do_out <= next_do;
         do_oe <= next_do_oe;
         dio_out <= next_dio;
         dio_oe <= next_dio_oe;
         loaded <= next_loaded;
         have_byte <= next_have_byte;
      end
      page_buf <= next_page_buf;
   end

   ////////////////////////////////////////////////////////////////////////////
   // self-timed execution and status

   sfo_pkg::sfo_exec_t ex_state, next_ex_state;
   logic [15:0] timer, next_timer;
   logic [7:0] prog_idx, next_prog_idx;
   logic [15:0] ex_page, next_ex_page;
   logic [7:0] nv, next_nv;
   logic next_wel, next_busy, next_arr_write, next_arr_erase;
   logic [23:0] next_arr_addr;
   logic [7:0] next_arr_wdata;

   always_comb
   begin
      status = nv;
      status[sfo_pkg::SR_WEL] = write_latch_flag;
      status[sfo_pkg::SR_BUSY] = busy; // R4
   end

   always_comb
   begin
      next_ex_state = ex_state;
      next_timer = timer;
      next_prog_idx = prog_idx;
      next_ex_page = ex_page;
      next_nv = nv;
      next_wel = write_latch_flag;
      next_busy = busy;
      next_arr_write = 1'b0;
      next_arr_erase = 1'b0;
      next_arr_addr = addr;
      next_arr_wdata = arr_wdata;
      case (ex_state)
         sfo_pkg::ex_idle:
         begin
            case (req)
               sfo_pkg::rq_wren: next_wel = 1'b1; // R14
               sfo_pkg::rq_wrdi: next_wel = 1'b0;
               sfo_pkg::rq_wrsr:
                  if (write_latch_flag && !(nv[sfo_pkg::SR_LOCK] && !wp_n_s)) // R6
                  begin
                     next_nv = (nv & ~sfo_pkg::SR_WR_MASK)
                        | (req_data & sfo_pkg::SR_WR_MASK); // R2
                     next_busy = 1'b1; // R4
                     next_timer = sfo_pkg::STATUS_WRITE_CYC;
                     next_ex_state = sfo_pkg::ex_wait;
                  end
               sfo_pkg::rq_pp:
                  if (write_latch_flag && !prot_hit(addr, nv)) // R20
                  begin
                     next_busy = 1'b1; // R19
                     next_prog_idx = '0;
                     next_ex_page = addr[sfo_pkg::ADDR_BITS-1:sfo_pkg::PAGE_BITS];
                     next_timer = sfo_pkg::PAGE_PROG_CYC;
                     next_ex_state = sfo_pkg::ex_prog;
                  end
               sfo_pkg::rq_se:
                  if (write_latch_flag && !prot_hit(addr, nv)) // R23
                  begin
                     next_busy = 1'b1; // R22
                     next_arr_addr = {addr[sfo_pkg::ADDR_BITS-1:sfo_pkg::SECTOR_BITS],
                                      12'h000};
                     next_arr_wdata = sfo_pkg::ERASED; // R21
                     next_arr_erase = 1'b1;
                     next_timer = sfo_pkg::SECTOR_ERASE_CYC;
                     next_ex_state = sfo_pkg::ex_wait;
                  end
               default: next_busy = busy;
            endcase
         end
         sfo_pkg::ex_prog:
         begin
            next_arr_addr = {ex_page, prog_idx};
            next_arr_wdata = page_buf[prog_idx];
            next_arr_write = loaded[prog_idx];
            next_prog_idx = prog_idx + 8'h01;
            if (prog_idx == sfo_pkg::PAGE_LAST)
               next_ex_state = sfo_pkg::ex_wait;
         end
         sfo_pkg::ex_wait:
         begin
            next_arr_addr = arr_addr;
            next_timer = timer - 16'h0001;
            if (timer == sfo_pkg::TIMER_LAST)
            begin
               next_busy = 1'b0;
               next_wel = 1'b0; // R5 R19 R22
               next_ex_state = sfo_pkg::ex_idle;
            end
         end
         default: next_ex_state = sfo_pkg::ex_idle;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ex_state <= sfo_pkg::ex_idle;
         timer <= '0;
         prog_idx <= '0;
         ex_page <= '0;
         nv <= sfo_pkg::SR_RESET;
         write_latch_flag <= 1'b0;
         busy <= 1'b0;
         arr_write <= 1'b0;
         arr_erase <= 1'b0;
         arr_addr <= '0;
         arr_wdata <= '0;
      end
      else
      begin
         ex_state <= next_ex_state;
         timer <= next_timer;
         prog_idx <= next_prog_idx;
         ex_page <= next_ex_page;
         nv <= next_nv;
         write_latch_flag <= next_wel;
         busy <= next_busy;
         arr_write <= next_arr_write;
         arr_erase <= next_arr_erase;
         arr_addr <= next_arr_addr;
         arr_wdata <= next_arr_wdata;
      end
   end

endmodule

// >>> rtl/sfo_sync.sv
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module sfo_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic ref_clk, // core clock
   input wire logic rst, // synchronous reset, active high
   input wire logic [W-1:0] async_in, // raw pin levels
   output logic [W-1:0] sync_out // synchronised levels
);

   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_sync_out;

   always_comb
   begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         stage1 <= RESET_VAL;
         sync_out <= RESET_VAL;
      end
      else
      begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end

endmodule

// >>> shared/sfo_pkg.sv
// Purpose: shared constants and types of the serial flash instruction sequencer
// Assumes: 20 MHz core clock; link clock sampled as an ordinary input
// Notes: self-timed cycle durations are plain defaults, not device figures
package sfo_pkg;

   // instruction codes
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_FAST = 8'h0B;
   localparam logic [7:0] OP_SE = 8'h20;
   localparam logic [7:0] OP_DUAL = 8'h3B;

   // status register layout
   localparam int SR_BUSY = 0;
   localparam int SR_WEL = 1;
   localparam int SR_BP_LO = 2;
   localparam int SR_BP_HI = 4;
   localparam int SR_TB = 5;
   localparam int SR_LOCK = 7;
   localparam logic [7:0] SR_WR_MASK = 8'hBC;
   localparam logic [7:0] SR_RESET = 8'h00;

   // array geometry
   localparam int ADDR_BITS = 24;
   localparam int PAGE_BITS = 8;
   localparam int PAGE_BYTES = 256;
   localparam int SECTOR_BITS = 12;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [23:0] ADDR_ONES = 24'hFF_FFFF;
   localparam logic [4:0] PROT_BASE_LOG = 5'h0F;
   localparam logic [2:0] BP_NONE = 3'h0;
   localparam logic [2:0] BP_ALL = 3'h7;
   localparam logic [7:0] PAGE_LAST = 8'hFF;

   // serial bit counting
   localparam logic [4:0] BYTE_END = 5'h07;
   localparam logic [4:0] ADDR_END = 5'h17;
   localparam logic [4:0] DUMMY_END = 5'h07;
   localparam logic [4:0] DUAL_END = 5'h06;
   localparam logic [4:0] STEP_ONE = 5'h01;
   localparam logic [4:0] STEP_TWO = 5'h02;

   // self-timed cycle durations
   localparam int CLK_MHZ = 20;
   localparam int STATUS_WRITE_TIME_US = 10;
   localparam int PAGE_PROG_TIME_US = 50;
   localparam int SECTOR_ERASE_TIME_US = 100;
   localparam logic [15:0] STATUS_WRITE_CYC = 16'(STATUS_WRITE_TIME_US * CLK_MHZ);
   localparam logic [15:0] PAGE_PROG_CYC = 16'(PAGE_PROG_TIME_US * CLK_MHZ);
   localparam logic [15:0] SECTOR_ERASE_CYC = 16'(SECTOR_ERASE_TIME_US * CLK_MHZ);
   localparam logic [15:0] TIMER_LAST = 16'h0001;

   // pin synchroniser reset value: {cs_n, sclk, data in, wp_n}
   localparam logic [3:0] PIN_RESET = 4'h9;

   typedef enum logic [3:0] {
      lk_cmd, lk_addr, lk_dummy, lk_read, lk_rdsr, lk_srdata, lk_ppdata, lk_end, lk_ignore
   } sfo_link_t;

   typedef enum logic [2:0] {
      rq_none, rq_wren, rq_wrdi, rq_wrsr, rq_pp, rq_se
   } sfo_req_t;

   typedef enum logic [1:0] {
      ex_idle, ex_prog, ex_wait
   } sfo_exec_t;

endpackage

// >>> testbench/serial_flash_read_write_ops_test.sv
// Purpose: self-checking bench of the flash sequencer
// Assumes: small array model, array does AND on program
// Notes: flags checked as {busy, latch}
`timescale 1ns/100ps
module serial_flash_read_write_ops_test;
   logic ref_clk, rst, cs_n, sclk, dio_line, dio_out, dio_oe, do_out, do_oe, wp_n;
   logic [23:0] arr_addr;
   logic [7:0] arr_rdata, arr_wdata, rx;
   logic arr_write, arr_erase, busy, write_latch_flag;
   logic [7:0] mem [0:65535];
   int err_total, checks;
   sfo_flash_seq dut (.ref_clk, .rst, .cs_n, .sclk, .dio_in(dio_line), .dio_out, .dio_oe, .do_out,
      .do_oe, .wp_n, .arr_addr, .arr_rdata, .arr_wdata, .arr_write, .arr_erase, .busy,
      .write_latch_flag);
   sfo_host host (.ref_clk, .cs_n, .sclk, .dio_line, .dio_out, .dio_oe, .do_out);
   assign arr_rdata = mem[arr_addr[15:0]];
   always @(posedge ref_clk)
   begin
      if (arr_write)
         mem[arr_addr[15:0]] <= mem[arr_addr[15:0]] & arr_wdata;
      if (arr_erase)
         for (int i = 0; i < 4096; i++)
            mem[{arr_addr[15:12], i[11:0]}] <= 8'hFF;
   end
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] st();
      return {6'h00, busy, write_latch_flag};
   endfunction
   task automatic results;
      if (err_total == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [7:0] code, input logic [23:0] a, input logic with_addr);
      host.start();
      host.shift(code, 1'b0, rx);
      if (with_addr)
         for (int i = 2; i >= 0; i--)
            host.shift(a[i * 8 +: 8], 1'b0, rx);
   endtask
   task automatic one(input logic [7:0] code, input logic [7:0] d);
      op(code, 24'h00_0000, 1'b0);
      host.shift(d, 1'b0, rx);
      host.stop();
   endtask
   task automatic idle;
      for (int i = 0; i < 3000 && busy; i++)
         @(negedge ref_clk);
      chk({7'h00, busy}, 8'h00);
      if (busy !== 1'b0)
         results();
   endtask
   task automatic rd(input logic [7:0] code, input logic [23:0] a, input logic [7:0] e0, e1);
      op(code, a, 1'b1);
      if (code != 8'h03)
      begin
         host.drv = (code != 8'h3B);
         host.shift(8'hC3, 1'b0, rx);
      end
      host.shift(8'h00, code == 8'h3B, rx);
      chk(rx, e0);
      host.shift(8'h00, code == 8'h3B, rx);
      chk(rx, e1);
      host.stop();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      wp_n = 1'b1;
      err_total = 0;
      checks = 0;
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'h00;
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      one(8'h01, 8'h9C);
      chk(st(), 8'h00);
      op(8'h06, 24'h00_0000, 1'b0);
      host.stop();
      chk(st(), 8'h01);
      op(8'h20, 24'h00_1234, 1'b1);
      host.stop();
      chk(st(), 8'h03);
      op(8'h03, 24'h00_11FE, 1'b1);
      host.shift(8'h00, 1'b0, rx);
      chk({7'h00, do_oe}, 8'h00);
      host.stop();
      chk(st(), 8'h03);
      idle();
      chk(st(), 8'h00);
      op(8'h06, 24'h00_0000, 1'b0);
      host.stop();
      op(8'h02, 24'h00_11FE, 1'b1);
      host.shift(8'hA5, 1'b0, rx);
      host.shift(8'h3C, 1'b0, rx);
      host.shift(8'h5A, 1'b0, rx);
      host.stop();
      chk(st(), 8'h03);
      idle();
      chk(st(), 8'h00);
      rd(8'h03, 24'h00_11FE, 8'hA5, 8'h3C);
      rd(8'h03, 24'h00_11FF, 8'h3C, 8'hFF);
      rd(8'h03, 24'h00_1100, 8'h5A, 8'hFF);
      rd(8'h0B, 24'h00_11FE, 8'hA5, 8'h3C);
      rd(8'h3B, 24'h00_11FE, 8'hA5, 8'h3C);
      op(8'h06, 24'h00_0000, 1'b0);
      host.stop();
      op(8'hAA, 24'h04_0000, 1'b1);
      host.stop();
      chk(st(), 8'h01);
      op(8'h01, 24'h00_0000, 1'b0);
      host.shift(8'hFF, 1'b0, rx);
      host.shift(8'h00, 1'b1, rx);
      host.stop();
      chk(st(), 8'h01);
      one(8'h01, 8'hFF);
      chk(st(), 8'h03);
      one(8'h05, 8'h00);
      chk(rx, 8'hBF);
      idle();
      chk(st(), 8'h00);
      op(8'h06, 24'h00_0000, 1'b0);
      host.stop();
      op(8'h20, 24'h00_1000, 1'b1);
      host.stop();
      chk(st(), 8'h01);
      op(8'h02, 24'h00_1100, 1'b1);
      host.shift(8'h00, 1'b0, rx);
      host.stop();
      chk(st(), 8'h01);
      rd(8'h03, 24'h00_1100, 8'h5A, 8'hFF);
      wp_n = 1'b0;
      one(8'h01, 8'h00);
      chk(st(), 8'h01);
      wp_n = 1'b1;
      one(8'h01, 8'h00);
      chk(st(), 8'h03);
      idle();
      results();
   end
endmodule

// >>> testbench/sfo_flash_seq_props.sv
// Purpose: port checks of the flash sequencer
// Assumes: synchronous reset, active high
// Notes: bound onto every sequencer instance
`timescale 1ns/100ps
module sfo_flash_seq_props (
   input wire logic ref_clk, // core clock
   input wire logic rst, // reset
   input wire logic cs_n, // chip select
   input wire logic do_oe, // output drive enable
   input wire logic dio_oe, // bidir drive enable
   input wire logic [23:0] arr_addr, // array address
   input wire logic [7:0] arr_wdata, // array data
   input wire logic arr_write, // program pulse
   input wire logic arr_erase, // erase pulse
   input wire logic busy, // cycle running
   input wire logic write_latch_flag // latch flag
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   chk_erase_busy: assert property (arr_erase |=> busy)
      else $error("erase without busy");
   chk_erase_fill: assert property (arr_erase |-> arr_wdata == 8'hFF && arr_addr[11:0] == 12'h000)
      else $error("erase data or alignment wrong");
   chk_erase_pulse: assert property (arr_erase |=> !arr_erase)
      else $error("erase pulse too long");
   chk_prog_busy: assert property (arr_write |-> busy)
      else $error("program outside cycle");
   chk_busy_start: assert property ($rose(busy) |-> write_latch_flag && $past(cs_n, 2))
      else $error("cycle started wrongly");
   chk_latch_clear: assert property ($fell(busy) |-> !write_latch_flag)
      else $error("latch kept after cycle");
   chk_latch_hold: assert property (busy |=> $stable(write_latch_flag) || $fell(busy))
      else $error("latch moved in cycle");
   chk_oe_idle: assert property (cs_n [*6] |-> !do_oe && !dio_oe)
      else $error("driving while deselected");
   chk_dual_pair: assert property (dio_oe |-> do_oe)
      else $error("bidir driven alone");
   cover property ($fell(busy));
   cover property (arr_erase);
   cover property (dio_oe);
endmodule
bind sfo_flash_seq sfo_flash_seq_props chk_i (.ref_clk, .rst, .cs_n, .do_oe, .dio_oe, .arr_addr,
   .arr_wdata, .arr_write, .arr_erase, .busy, .write_latch_flag);

// >>> testbench/sfo_host.sv
// Purpose: host side of the serial link, 400 ns bit clock
// Assumes: 50 ns core clock; changes at its falling edge
// Notes: a released bidir line shows the inverse of its last value
`timescale 1ns/100ps
module sfo_host (
   input wire logic ref_clk, // core clock
   output logic cs_n, // chip select
   output logic sclk, // link clock, low outside frames
   output logic dio_line, // resolved bidir line
   input wire logic dio_out, // device drive value
   input wire logic dio_oe, // device drive enable
   input wire logic do_out // device data output
);
   logic drv = 1'b1;
   logic val = 1'b0;
   initial cs_n = 1'b1;
   initial sclk = 1'b0;
   assign dio_line = dio_oe ? dio_out : (drv ? val : ~val);
   task automatic half;
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic start;
      drv = 1'b1;
      cs_n = 1'b0;
   endtask
   task automatic stop;
      half();
      cs_n = 1'b1;
      half();
   endtask
   // sends msb first; samples just before each fall
   task automatic shift(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < (dual ? 4 : 8); i++)
      begin
         val = tx[7 - i];
         half();
         sclk = 1'b1;
         half();
         rx = dual ? {rx[5:0], do_out, dio_line} : {rx[6:0], do_out};
         sclk = 1'b0;
      end
   endtask
endmodule
